// ===== lpoc_pkg.sv
// Overview of operation
// RULE1: A 9-bit reference counter counts edges of the accurate reference clock, either the precision oscillator or the watch crystal.
// RULE2: A 10-bit low-power counter counts edges of the low-power oscillator, either directly or through a divide-by-4 stage.
// RULE3: The trim register is 8 bits wide, only its low 4 bits drive the oscillator trim, a larger value lowers the frequency, and the upper bits read as zero.
// RULE4: While a calibration runs, both counters stop when the reference counter reaches 0x1FF.
// RULE5: Software compares the two counts afterwards and lowers the trim if the reference count is larger, raises it if smaller, and leaves it if equal.
// RULE6: Software runs the calibration again after every trim change to check the new frequency.
// RULE7: Control bit 4 picks the reference, one for the watch crystal and zero for the precision oscillator.
// RULE8: Writing one to control bit 3 clears both counters and stops the calibration logic.
// RULE9: Writing one to control bit 2 clears the low-power counter, and one to bit 1 clears the reference counter.
// RULE10: Control bit 0 enables calibration, setting it starts counting and clearing it aborts a running calibration.
// RULE11: Status bit 1 is set when a calibration completes and is cleared by a read of the low-power counter register.
// RULE12: Status bit 0 reads one while a calibration runs and zero once it has finished.
// RULE13: Software switches the PLL source to the precision oscillator or the crystal before calibrating, so trim changes do not break lock.
// RULE14: A run lasts about 4 ms on the precision reference and about 16 ms on the crystal, set by the terminal count at the reference rate.
// RULE15: With the crystal reference the low-power counter counts through the divide-by-4 path, otherwise directly, so both counters run at the same nominal rate.
`default_nettype none

package lpoc_pkg;

  // ---------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [31:0] ADDR_TRIM = 32'hffff042c;
  localparam logic [31:0] ADDR_CTRL = 32'hffff0440;
  localparam logic [31:0] ADDR_STAT = 32'hffff0444;
  localparam logic [31:0] ADDR_REFC = 32'hffff0448;
  localparam logic [31:0] ADDR_LPC  = 32'hffff044c;

  // ---------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------
  localparam int          TRIM_W    = 4;
  localparam int          REF_W     = 9;
  localparam int          LP_W      = 10;
  localparam int          LP_DIV    = 4;
  localparam logic [3:0]  TRIM_RST  = 4'h8;
  localparam logic [8:0]  REF_TERM  = 9'h1ff;

  // ---------------------------------------------------------------------
  // Control and status bit positions
  // ---------------------------------------------------------------------
  localparam int CTL_EN     = 0;
  localparam int CTL_CLRREF = 1;
  localparam int CTL_CLRLP  = 2;
  localparam int CTL_RESET  = 3;
  localparam int CTL_SRC    = 4;
  localparam int STA_BUSY   = 0;
  localparam int STA_DONE   = 1;

  // ---------------------------------------------------------------------
  // Nominal run times
  // ---------------------------------------------------------------------
  localparam int RUN_PREC_MS = 4;
  localparam int RUN_XTAL_MS = 16;

endpackage : lpoc_pkg

`default_nettype wire

// ===== lpoc_cnt_if.sv
`default_nettype none

interface lpoc_cnt_if #(
  parameter int W = 9
);
  logic         tick;
  logic         run;
  logic         clear;
  logic [W-1:0] count;

  modport ctrl (output tick, output run, output clear, input count);
  modport cnt  (input tick, input run, input clear, output count);
endinterface : lpoc_cnt_if

`default_nettype wire

// ===== lpoc_edge.sv
`default_nettype none

module lpoc_edge #(
  parameter int DIV = 4
) (
  input  wire logic clk,      // System clock
  input  wire logic rstn,     // Async reset, active low
  input  wire logic sig,      // Slow clock, sampled
  output logic      rise,     // One pulse per rising edge
  output logic      riseDiv   // One pulse per DIV rising edges
);
  typedef struct packed {
    logic                   prev;
    logic [$clog2(DIV)-1:0] divCnt;
  } lpoc_edge_t;

  localparam logic [$clog2(DIV)-1:0] DIV_LAST = ($clog2(DIV))'(DIV - 1);

  lpoc_edge_t st;
  lpoc_edge_t next_st;

  assign rise    = sig & ~st.prev;
  assign riseDiv = rise & (st.divCnt == DIV_LAST);

  always_comb begin
    next_st      = st;
    next_st.prev = sig;
    if (rise) begin
      next_st.divCnt = st.divCnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : lpoc_edge

`default_nettype wire

// ===== lpoc_counter.sv
`default_nettype none

module lpoc_counter #(
  parameter int W = 9
) (
  input  wire logic clk,     // System clock
  input  wire logic rstn,    // Async reset, active low
  lpoc_cnt_if.cnt   bus      // Tick, run, clear in; count out
);
  typedef struct packed {
    logic [W-1:0] count;
  } lpoc_cnt_t;

  lpoc_cnt_t st;
  lpoc_cnt_t next_st;

  assign bus.count = st.count;

  always_comb begin
    next_st = st;
    // Clear beats counting so a clear never leaves a stale count
    if (bus.clear) begin
      next_st.count = '0;
    end else if (bus.run && bus.tick) begin
      next_st.count = st.count + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : lpoc_counter

`default_nettype wire

// ===== lpoc_calib.sv
// Our own choice: the Avalon-MM slave port.
`default_nettype none

module lpoc_calib (
  input  wire logic        clk,            // System clock, 250 MHz
  input  wire logic        rstn,           // Async reset, active low
  input  wire logic [31:0] avsAddress,     // Byte address
  input  wire logic        avsRead,        // Read request
  input  wire logic        avsWrite,       // Write request
  input  wire logic [31:0] avsWriteData,   // Write data
  input  wire logic [3:0]  avsByteEnable,  // Byte lanes
  output logic [31:0]      avsReadData,    // Read data
  output logic             avsWaitRequest, // Stall
  input  wire logic        precClkIn,      // Precision oscillator
  input  wire logic        xtalClkIn,      // Watch crystal
  input  wire logic        lpClkIn,        // Low-power oscillator
  output logic [lpoc_pkg::TRIM_W-1:0] lpTrim // Oscillator trim
);
  import lpoc_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [TRIM_W-1:0] trim;
    logic              src;
    logic              en;
    logic              running;
    logic              done;
    logic              busAck;
    logic [31:0]       rdData;
  } lpoc_regs_t;

  lpoc_regs_t st;
  lpoc_regs_t next_st;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction : hit

  // ---------------------------------------------------------------------
  // Clock edges and counters
  // ---------------------------------------------------------------------
  logic precRise;
  logic xtalRise;
  logic refRise;
  logic lpRise;
  logic lpRiseDiv;

  // One detector per pin: a source switch never fakes a reference edge
  assign refRise = st.src ? xtalRise : precRise; // RULE7

  lpoc_edge #(.DIV(LP_DIV)) uRefEdge (
    .clk     (clk),
    .rstn    (rstn),
    .sig     (precClkIn),
    .rise    (precRise),
    .riseDiv ()
  );

  lpoc_edge #(.DIV(LP_DIV)) uXtalEdge (
    .clk     (clk),
    .rstn    (rstn),
    .sig     (xtalClkIn),
    .rise    (xtalRise),
    .riseDiv ()
  );

  lpoc_edge #(.DIV(LP_DIV)) uLpEdge (
    .clk     (clk),
    .rstn    (rstn),
    .sig     (lpClkIn),
    .rise    (lpRise),
    .riseDiv (lpRiseDiv)
  );

  lpoc_cnt_if #(.W(REF_W)) refIf ();
  lpoc_cnt_if #(.W(LP_W))  lpIf ();

  lpoc_counter #(.W(REF_W)) uRefCnt (
    .clk  (clk),
    .rstn (rstn),
    .bus  (refIf.cnt)
  );

  lpoc_counter #(.W(LP_W)) uLpCnt (
    .clk  (clk),
    .rstn (rstn),
    .bus  (lpIf.cnt)
  );

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------
  logic        req;
  logic        wrAcc;
  logic        rdAcc;
  logic        wrCtrl;
  logic        wrTrim;
  logic        rdLp;
  logic        refTerm;
  logic        counting;
  logic [31:0] rdMux;

  assign req     = avsRead | avsWrite;
  assign wrAcc   = avsWrite & st.busAck & avsByteEnable[0];
  assign rdAcc   = avsRead & st.busAck;
  assign wrCtrl  = wrAcc & hit(avsAddress, ADDR_CTRL);
  assign wrTrim  = wrAcc & hit(avsAddress, ADDR_TRIM);
  assign rdLp    = rdAcc & hit(avsAddress, ADDR_LPC);
  // Run length is simply the terminal count at the reference rate
  assign refTerm = (refIf.count == REF_TERM); // RULE4 RULE14
  assign counting = st.running & ~refTerm; // RULE4

  assign refIf.tick  = refRise; // RULE1
  assign lpIf.tick   = st.src ? lpRiseDiv : lpRise; // RULE2 RULE15
  assign refIf.run   = counting;
  assign lpIf.run    = counting;
  assign refIf.clear = wrCtrl & (avsWriteData[CTL_RESET] |
                                 avsWriteData[CTL_CLRREF]); // RULE8 RULE9
  assign lpIf.clear  = wrCtrl & (avsWriteData[CTL_RESET] |
                                 avsWriteData[CTL_CLRLP]); // RULE8 RULE9

  assign avsWaitRequest = req & ~st.busAck;
  assign avsReadData    = st.rdData;
  assign lpTrim         = st.trim; // RULE3

  always_comb begin
    rdMux = '0;
    if (hit(avsAddress, ADDR_TRIM)) begin
      rdMux[TRIM_W-1:0] = st.trim; // RULE3
    end else if (hit(avsAddress, ADDR_CTRL)) begin
      rdMux[CTL_SRC] = st.src;
      rdMux[CTL_EN]  = st.en;
    end else if (hit(avsAddress, ADDR_STAT)) begin
      rdMux[STA_DONE] = st.done;
      rdMux[STA_BUSY] = st.running; // RULE12
    end else if (hit(avsAddress, ADDR_REFC)) begin
      rdMux[REF_W-1:0] = refIf.count;
    end else if (hit(avsAddress, ADDR_LPC)) begin
      rdMux[LP_W-1:0] = lpIf.count;
    end
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    next_st        = st;
    // One wait state: data is captured while waitrequest is high
    next_st.busAck = req & ~st.busAck;
    if (req && !st.busAck) begin
      next_st.rdData = avsRead ? rdMux : '0;
    end
    if (st.running && refTerm) begin
      next_st.running = 1'b0; // RULE4 RULE12
    end
    if (wrTrim) begin
      // Upper trim bits are not stored and read back as zero
      next_st.trim = avsWriteData[TRIM_W-1:0]; // RULE3
    end
    if (wrCtrl) begin
      next_st.src = avsWriteData[CTL_SRC]; // RULE7
      if (avsWriteData[CTL_RESET]) begin
        next_st.en      = 1'b0; // RULE8
        next_st.running = 1'b0; // RULE8
      end else begin
        next_st.en      = avsWriteData[CTL_EN]; // RULE10
        next_st.running = avsWriteData[CTL_EN]; // RULE10
      end
    end
    // Completion set wins over the read-side clear
    if (st.running && refTerm) begin
      next_st.done = 1'b1; // RULE11
    end else if (rdLp) begin
      next_st.done = 1'b0; // RULE11
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st      <= '0;
      st.trim <= TRIM_RST;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_ctrl_wr(int b, logic v);
    wrCtrl && (avsWriteData[b] == v);
  endsequence

  sequence s_zero_counts;
    (refIf.count == '0) && (lpIf.count == '0);
  endsequence

  property p_ref_step;
    counting && refRise && !refIf.clear |=>
      refIf.count == $past(refIf.count) + 1'b1;
  endproperty
  a_ref_step: assert property (p_ref_step) // RULE1
    else $error("reference counter did not step");

  property p_lp_direct;
    counting && !st.src && lpRise && !lpIf.clear |=>
      lpIf.count == $past(lpIf.count) + 1'b1;
  endproperty
  a_lp_direct: assert property (p_lp_direct) // RULE2
    else $error("low-power counter missed a direct edge");

  property p_lp_div;
    st.src && lpRise && !lpRiseDiv && !lpIf.clear |=> $stable(lpIf.count);
  endproperty
  a_lp_div: assert property (p_lp_div) // RULE15
    else $error("low-power counter stepped between divided edges");

  property p_trim_wr;
    wrTrim |=> lpTrim == $past(avsWriteData[TRIM_W-1:0]);
  endproperty
  a_trim_wr: assert property (p_trim_wr) // RULE3
    else $error("trim write not applied");

  property p_stop;
    $rose(st.done) |-> refIf.count == REF_TERM && !st.running;
  endproperty
  a_stop: assert property (p_stop) // RULE4
    else $error("completion not at terminal count");

  property p_hold;
    !st.running && !refIf.clear && !lpIf.clear |=>
      $stable(refIf.count) && $stable(lpIf.count);
  endproperty
  a_hold: assert property (p_hold) // RULE4
    else $error("counter moved while idle");

  property p_cal_reset;
    s_ctrl_wr(CTL_RESET, 1'b1) |=> s_zero_counts ##0 !st.running;
  endproperty
  a_cal_reset: assert property (p_cal_reset) // RULE8
    else $error("calibration reset incomplete");

  property p_clr_ref;
    s_ctrl_wr(CTL_CLRREF, 1'b1) |=> refIf.count == '0;
  endproperty
  a_clr_ref: assert property (p_clr_ref) // RULE9
    else $error("reference clear ignored");

  property p_src;
    wrCtrl |=> st.src == $past(avsWriteData[CTL_SRC]);
  endproperty
  a_src: assert property (p_src) // RULE7
    else $error("source select not applied");

  property p_abort;
    s_ctrl_wr(CTL_EN, 1'b0) |=> !st.running ##1 !st.running;
  endproperty
  a_abort: assert property (p_abort) // RULE10
    else $error("abort did not stop calibration");

  property p_done_clr;
    rdLp && !(st.running && refTerm) |=> !st.done;
  endproperty
  a_done_clr: assert property (p_done_clr) // RULE11
    else $error("complete flag not cleared by read");

  property p_busy_rd;
    rdAcc && hit(avsAddress, ADDR_STAT) |->
      avsReadData[STA_BUSY] == $past(st.running);
  endproperty
  a_busy_rd: assert property (p_busy_rd) // RULE12
    else $error("busy bit misreported");

  property p_answer;
    req && !st.busAck |=> !avsWaitRequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no answer after one wait state");
endmodule : lpoc_calib

`default_nettype wire

// ===== tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lpoc_pkg::*;

  typedef struct {
    logic [31:0] exp;
    int          tol;
    bit          chkOn;
  } lpoc_note_t;

  logic        clk;
  logic        rstn;
  logic [31:0] avsAddress;
  logic [31:0] avsWriteData;
  logic [31:0] avsReadData;
  logic [31:0] lastRd;
  logic [31:0] refV;
  logic [31:0] lpV;
  logic        avsRead;
  logic        avsWrite;
  logic        avsWaitRequest;
  logic        precClkIn;
  logic        xtalClkIn;
  logic        lpClkIn;
  logic [3:0]  avsByteEnable;
  logic [3:0]  lpTrim;
  logic [3:0]  trimVal;
  lpoc_note_t  noteQ[$];
  lpoc_note_t  note;
  int          errorCnt = 0;
  int          numChecks = 0;
  int          cyc = 0;
  int          pH = 4;
  int          xH = 4;
  int          lH = 4;

  lpoc_calib dut (
    .clk(clk), .rstn(rstn), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .precClkIn(precClkIn),
    .xtalClkIn(xtalClkIn), .lpClkIn(lpClkIn), .lpTrim(lpTrim)
  );

  // ---------------------------------------------------------------------
  // Clocks
  // ---------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Slow clocks stay whole clk cycles high and low, as the sampler needs
  always @(posedge clk) begin
    cyc       <= cyc + 1;
    precClkIn <= (cyc % (2 * pH)) < pH;
    xtalClkIn <= (cyc % (2 * xH)) < xH;
    lpClkIn   <= (cyc % (2 * lH)) < lH;
  end

  // ---------------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp, input int tol);
    logic [31:0] d;
    numChecks++;
    d = (got > exp) ? got - exp : exp - got;
    if (got !== exp && ((^got) === 1'bx || d > tol)) begin
      errorCnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Read data is judged at the accept edge only
  always @(posedge clk) begin
    if (avsRead === 1'b1 && avsWaitRequest === 1'b0) begin
      lastRd = avsReadData;
      if (noteQ.size() == 0) begin
        errorCnt++;
        $display("ERROR t=%0t got=%h exp=%h", $time, avsReadData, 0);
      end else begin
        note = noteQ.pop_front();
        if (note.chkOn) chk(avsReadData, note.exp, note.tol);
      end
    end
  end

  // ---------------------------------------------------------------------
  // Bus master
  // ---------------------------------------------------------------------
  task automatic bus(input bit wr, input logic [31:0] a, d,
                     input logic [3:0] be);
    avsAddress    <= a;
    avsWriteData  <= d;
    avsByteEnable <= be;
    avsWrite      <= wr;
    avsRead       <= !wr;
    // No cycle budget here: only the watchdog ends a stuck request
    do begin
      @(posedge clk);
    end while (avsWaitRequest !== 1'b0);
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
    // Idle cycle so no signal is assigned twice in one step
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [31:0] a, d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [31:0] a, e, input int t);
    noteQ.push_back('{e, t, 1'b1});
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  task automatic poll(input logic [31:0] a);
    noteQ.push_back('{32'h0, 0, 1'b0});
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : poll

  task automatic runCal(input logic [7:0] ctl, input int per);
    int t0;
    int n;
    wr(ADDR_CTRL, {24'h0, ctl});
    t0 = cyc;
    rd(ADDR_STAT, 32'h1, 0);
    n = 0;
    do begin
      poll(ADDR_STAT);
      n++;
    end while (lastRd[0] !== 1'b0 && n < 5000);
    if (n >= 5000) begin
      errorCnt++;
      stopTest();
    end
    chk(32'(cyc - t0), 32'(511 * per), per + 12);
    rd(ADDR_STAT, 32'h2, 0);
    rd(ADDR_REFC, 32'h1ff, 0);
  endtask : runCal

  task automatic stopTest;
    $display("checks=%0d errors=%0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stopTest

  initial begin
    repeat (40000) @(posedge clk);
    errorCnt++;
    stopTest();
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    rstn          = 1'b0;
    avsAddress    = 32'h0;
    avsWriteData  = 32'h0;
    avsByteEnable = 4'h0;
    avsRead       = 1'b0;
    avsWrite      = 1'b0;
    precClkIn     = 1'b0;
    xtalClkIn     = 1'b0;
    lpClkIn       = 1'b0;
    void'($urandom(32'h7991));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(ADDR_TRIM, 32'h8, 0);
    rd(ADDR_CTRL, 32'h0, 0);
    rd(ADDR_STAT, 32'h0, 0);
    rd(ADDR_REFC, 32'h0, 0);
    rd(ADDR_LPC, 32'h0, 0);
    chk({28'h0, lpTrim}, 32'h8, 0);
    repeat (4) begin
      trimVal = 4'($urandom);
      wr(ADDR_TRIM, {28'h0, trimVal});
      chk({28'h0, lpTrim}, {28'h0, trimVal}, 0);
      rd(ADDR_TRIM, {28'h0, trimVal}, 0);
    end
    // Lane 0 off and an unmapped place must both leave state alone
    bus(1'b1, ADDR_TRIM, {28'h0, ~trimVal}, 4'he);
    rd(ADDR_TRIM, {28'h0, trimVal}, 0);
    wr(32'hffff0450, 32'hff);
    rd(32'hffff0450, 32'h0, 0);
    // Precision reference, identical rates on both counters
    runCal(8'h07, 8);
    poll(ADDR_REFC);
    refV = lastRd;
    poll(ADDR_LPC);
    lpV = lastRd;
    chk(lpV, refV, 0);
    rd(ADDR_STAT, 32'h0, 0);
    repeat (50) @(posedge clk);
    rd(ADDR_LPC, lpV, 0);
    trimVal = 4'(trimVal + (refV < lpV) - (refV > lpV));
    wr(ADDR_TRIM, {28'h0, trimVal});
    // Crystal reference; a wrong mux would finish at the precision rate
    @(negedge clk);
    pH = 3;
    xH = 8;
    lH = 2;
    @(posedge clk);
    runCal(8'h17, 16);
    rd(ADDR_CTRL, 32'h11, 0);
    poll(ADDR_LPC);
    chk(lastRd, 32'h1ff, 1);
    // Abort, then single clears
    @(negedge clk);
    pH = 4;
    lH = 4;
    @(posedge clk);
    wr(ADDR_CTRL, 32'h07);
    repeat (200) @(posedge clk);
    rd(ADDR_STAT, 32'h1, 0);
    wr(ADDR_CTRL, 32'h00);
    rd(ADDR_STAT, 32'h0, 0);
    wr(ADDR_CTRL, 32'h04);
    rd(ADDR_LPC, 32'h0, 0);
    poll(ADDR_REFC);
    chk(32'(lastRd == 32'h0), 32'h0, 0);
    wr(ADDR_CTRL, 32'h02);
    rd(ADDR_REFC, 32'h0, 0);
    // Calibration reset in mid-run
    wr(ADDR_CTRL, 32'h01);
    repeat (200) @(posedge clk);
    wr(ADDR_CTRL, 32'h08);
    rd(ADDR_CTRL, 32'h0, 0);
    rd(ADDR_STAT, 32'h0, 0);
    rd(ADDR_REFC, 32'h0, 0);
    rd(ADDR_LPC, 32'h0, 0);
    stopTest();
  end

endmodule : tb

`default_nettype wire
